// ===== verilog/tmw_consts.vh
/*
 * Constants for the 8-bit timer waveform block: mode and output-mode
 * encodings, clock select codes, prescale taps and extreme count values.
 * Assumes inclusion by the timer design files and the verification files.
 */
`ifndef TMW_CONSTS_VH
`define TMW_CONSTS_VH

`define TMW_WGM_NORMAL   2'h0
`define TMW_WGM_PCPWM    2'h1
`define TMW_WGM_CTC      2'h2
`define TMW_WGM_FASTPWM  2'h3

`define TMW_COM_OFF      2'h0
`define TMW_COM_TOGGLE   2'h1
`define TMW_COM_CLEAR    2'h2
`define TMW_COM_SET      2'h3

`define TMW_CS_STOP      3'h0
`define TMW_CS_DIV1      3'h1
`define TMW_CS_DIV8      3'h2
`define TMW_CS_DIV64     3'h3
`define TMW_CS_DIV256    3'h4
`define TMW_CS_DIV1024   3'h5
`define TMW_CS_EXTFALL   3'h6
`define TMW_CS_EXTRISE   3'h7

`define TMW_BOTTOM       8'h00
`define TMW_MAX          8'hFF

`define TMW_PRE_W        10
`define TMW_TAP8         10'h007
`define TMW_TAP64        10'h03F
`define TMW_TAP256       10'h0FF
`define TMW_TAP1024      10'h3FF

`endif

// ===== verilog/tmw_tick_gen.v
/*
 * Timer tick generator: a free-running prescaler and the external count
 * input edge detector, selected by the clock select field.
 * Assumes the external input is asynchronous and clk is the I/O clock.
 */
`timescale 1ns/1ps
`include "tmw_consts.vh"

module tmw_tick_gen (
    clk,
    rst_n,
    clock_select_field,
    external_count_input,
    timer_tick
);
    input  wire       clk;
    input  wire       rst_n;
    input  wire [2:0] clock_select_field;
    input  wire       external_count_input;
    output reg        timer_tick;

    reg  [`TMW_PRE_W-1:0] pre_reg;
    reg                   ext_s1_reg;
    reg                   ext_s2_reg;
    reg                   ext_s3_reg;
    reg                   tick_next;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and synchroniser.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg    <= {`TMW_PRE_W{1'b0}};
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            pre_reg    <= pre_reg + 10'h001;
            ext_s1_reg <= external_count_input;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick selection; registered so the tick is a clean one-cycle enable.
    always @* begin
        case (clock_select_field)
            `TMW_CS_DIV1:    tick_next = 1'b1;
            `TMW_CS_DIV8:    tick_next = ({7'h00, pre_reg[2:0]} == `TMW_TAP8);
            `TMW_CS_DIV64:   tick_next = ({4'h0, pre_reg[5:0]} == `TMW_TAP64);
            `TMW_CS_DIV256:  tick_next = ({2'h0, pre_reg[7:0]} == `TMW_TAP256);
            `TMW_CS_DIV1024: tick_next = (pre_reg == `TMW_TAP1024);
            `TMW_CS_EXTFALL: tick_next = ext_s3_reg & ~ext_s2_reg;
            `TMW_CS_EXTRISE: tick_next = ext_s2_reg & ~ext_s3_reg;
            default:         tick_next = 1'b0;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_tick <= 1'b0;
        end else begin
            timer_tick <= tick_next;
        end
    end

endmodule

// ===== verilog/tmw_timer.v
/*
 * 8-bit timer with clear-on-compare, fast PWM and phase-correct PWM
 * waveform generation, compare buffering, flags and the output pin.
 * Assumes software control arrives as same-clock ports; flags are
 * cleared by one-cycle clear strobes from the surrounding logic.
 */
`timescale 1ns/1ps
`include "tmw_consts.vh"

module tmw_timer (
    clk,
    rst_n,
    waveform_mode_field,
    compare_output_mode_field,
    clock_select_field,
    external_count_input,
    compare_wr,
    compare_wdata,
    counter_wr,
    counter_wdata,
    compare_flag_clr,
    overflow_flag_clr,
    port_data,
    port_dir_out,
    counter_value,
    compare_value_reg,
    compare_match_flag,
    overflow_flag,
    pin_out,
    pin_oe
);
    input  wire       clk;
    input  wire       rst_n;
    input  wire [1:0] waveform_mode_field;
    input  wire [1:0] compare_output_mode_field;
    input  wire [2:0] clock_select_field;
    input  wire       external_count_input;
    input  wire       compare_wr;
    input  wire [7:0] compare_wdata;
    input  wire       counter_wr;
    input  wire [7:0] counter_wdata;
    input  wire       compare_flag_clr;
    input  wire       overflow_flag_clr;
    input  wire       port_data;
    input  wire       port_dir_out;
    output reg  [7:0] counter_value;
    output reg  [7:0] compare_value_reg;
    output reg        compare_match_flag;
    output reg        overflow_flag;
    output reg        pin_out;
    output reg        pin_oe;

    wire       timer_tick;
    reg  [7:0] compare_buf_reg;
    reg        count_down_reg;
    reg        block_match_reg;
    reg        compare_output_reg;
    reg  [7:0] cnt_next;
    reg        dir_next;
    reg  [7:0] ocr_next;
    reg        oc_next;
    reg        match;
    reg        ovf_evt;

    wire is_pc   = (waveform_mode_field == `TMW_WGM_PCPWM);
    wire is_fast = (waveform_mode_field == `TMW_WGM_FASTPWM);
    wire is_ctc  = (waveform_mode_field == `TMW_WGM_CTC);
    wire is_pwm  = is_pc | is_fast;

    // Output level for a phase-correct match in a given direction.
    function oc_pc_level;
        input [1:0] com;
        input       down;
        begin
            oc_pc_level = (com == `TMW_COM_CLEAR) ? down : ~down;
        end
    endfunction

    // One count step up or down. The wrap modulo 256 is intended: fast
    // mode and the free count rely on MAX stepping to BOTTOM.
    function [7:0] cnt_step;
        input [7:0] value;
        input       down;
        begin
            if (down) begin
                cnt_step = value - 8'h01;
            end else begin
                cnt_step = value + 8'h01;
            end
        end
    endfunction

    // True when the count sits at MAX (top set) or at BOTTOM.
    function at_end;
        input [7:0] value;
        input       top;
        begin
            at_end = top ? (value == `TMW_MAX) : (value == `TMW_BOTTOM);
        end
    endfunction

    // Decoded ends of the range, shared by sequencing and the output.
    wire at_max    = at_end(counter_value, 1'b1);
    wire at_bottom = at_end(counter_value, 1'b0);

    ////////////////////////////////////////////////////////////////////////
    // Tick generation.
    tmw_tick_gen u_tick (
        .clk                  (clk),
        .rst_n                (rst_n),
        .clock_select_field   (clock_select_field),
        .external_count_input (external_count_input),
        .timer_tick           (timer_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter sequencing and compare register update.
    always @* begin
        cnt_next = counter_value;
        dir_next = count_down_reg;
        ocr_next = compare_value_reg;
        match    = timer_tick & ~block_match_reg &
                   (counter_value == compare_value_reg);
        ovf_evt  = 1'b0;
        if (!is_pwm && compare_wr) begin
            ocr_next = compare_wdata;
        end
        if (timer_tick) begin
            case (waveform_mode_field)
                `TMW_WGM_PCPWM: begin
                    // The direction turns on the end tick itself, so
                    // MAX and BOTTOM each stand for one tick.
                    if (at_max) begin
                        dir_next = 1'b1;
                    end else if (at_bottom) begin
                        dir_next = 1'b0;
                    end
                    cnt_next = cnt_step(counter_value, dir_next);
                    if (at_max) begin
                        ocr_next = compare_buf_reg;
                    end
                    ovf_evt = at_bottom;
                end
                `TMW_WGM_FASTPWM: begin
                    cnt_next = cnt_step(counter_value, 1'b0);
                    ovf_evt  = at_max;
                    // The buffer lands on the MAX tick, so the new
                    // compare value is live from bottom on.
                    if (at_max) begin
                        ocr_next = compare_buf_reg;
                    end
                end
                `TMW_WGM_CTC: begin
                    cnt_next = match ? `TMW_BOTTOM
                                     : cnt_step(counter_value, 1'b0);
                    ovf_evt  = at_max;
                end
                default: begin
                    cnt_next = cnt_step(counter_value, 1'b0);
                    ovf_evt  = at_max;
                end
            endcase
        end
        // A software write beats the tick so a written count is
        // never overtaken by the step it raced with.
        if (counter_wr) begin
            cnt_next = counter_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Waveform output register.
    always @* begin
        oc_next = compare_output_reg;
        case (waveform_mode_field)
            `TMW_WGM_FASTPWM: begin
                if (timer_tick && counter_value == `TMW_MAX &&
                    compare_output_mode_field[1]) begin
                    oc_next = ~compare_output_mode_field[0];
                    if (compare_value_reg == `TMW_BOTTOM && match) begin
                        oc_next = compare_output_mode_field[0];
                    end
                end else if (match && compare_value_reg != `TMW_MAX) begin
                    if (compare_output_mode_field == `TMW_COM_TOGGLE) begin
                        oc_next = ~compare_output_reg;
                    end else if (compare_output_mode_field[1]) begin
                        oc_next = compare_output_mode_field[0];
                    end
                end else if (match && compare_output_mode_field ==
                             `TMW_COM_TOGGLE) begin
                    oc_next = ~compare_output_reg;
                end
            end
            `TMW_WGM_PCPWM: begin
                if (compare_output_mode_field[1] && timer_tick) begin
                    if (at_max) begin
                        oc_next = oc_pc_level(compare_output_mode_field,
                            compare_buf_reg == `TMW_MAX);
                    end else if (at_bottom) begin
                        // Bottom is checked before a match: a bottom
                        // compare acts as an up-count match there, so
                        // the output stays at its up-side level.
                        oc_next = oc_pc_level(compare_output_mode_field,
                            compare_value_reg != `TMW_BOTTOM);
                    end else if (match) begin
                        oc_next = oc_pc_level(compare_output_mode_field,
                            count_down_reg);
                    end
                end
            end
            default: begin
                if (match) begin
                    case (compare_output_mode_field)
                        `TMW_COM_TOGGLE: oc_next = ~compare_output_reg;
                        `TMW_COM_CLEAR:  oc_next = 1'b0;
                        `TMW_COM_SET:    oc_next = 1'b1;
                        default:         oc_next = compare_output_reg;
                    endcase
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State and outputs.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value      <= 8'h00;
            compare_value_reg  <= 8'h00;
            compare_buf_reg    <= 8'h00;
            count_down_reg     <= 1'b0;
            block_match_reg    <= 1'b0;
            compare_output_reg <= 1'b0;
            compare_match_flag <= 1'b0;
            overflow_flag      <= 1'b0;
            pin_out            <= 1'b0;
            pin_oe             <= 1'b0;
        end else begin
            counter_value     <= cnt_next;
            count_down_reg    <= dir_next;
            compare_value_reg <= ocr_next;
            if (compare_wr) begin
                compare_buf_reg <= compare_wdata;
            end
            // A write holds the block until the next tick consumes it.
            if (counter_wr) begin
                block_match_reg <= 1'b1;
            end else if (timer_tick) begin
                block_match_reg <= 1'b0;
            end
            compare_output_reg <= oc_next;
            // Set wins over a clear in the same cycle.
            if (match) begin
                compare_match_flag <= 1'b1;
            end else if (compare_flag_clr) begin
                compare_match_flag <= 1'b0;
            end
            if (ovf_evt) begin
                overflow_flag <= 1'b1;
            end else if (overflow_flag_clr) begin
                overflow_flag <= 1'b0;
            end
            // Output pin mux follows the next output state.
            pin_out <= (compare_output_mode_field != `TMW_COM_OFF) ?
                       oc_next : port_data;
            // The enable mirrors direction only; the level is kept anyway.
            pin_oe  <= port_dir_out;
        end
    end

endmodule

// ===== verification/tmw_properties.sv
/* Checker for the 8-bit timer waveform block, bound to tmw_timer ports.
   Assumes one clock, clk, and the asynchronous active-low reset rst_n. */
`timescale 1ns/1ps
`include "tmw_consts.vh"
////////////////////////////////////////////////////////////////////////////
module tmw_properties (
    input logic       clk,
    input logic       rst_n,
    input logic [1:0] waveform_mode_field,
    input logic [1:0] compare_output_mode_field,
    input logic [2:0] clock_select_field,
    input logic       compare_wr,
    input logic       counter_wr,
    input logic [7:0] counter_wdata,
    input logic       compare_flag_clr,
    input logic       port_dir_out,
    input logic [7:0] counter_value,
    input logic [7:0] compare_value_reg,
    input logic       compare_match_flag,
    input logic       overflow_flag,
    input logic       pin_out,
    input logic       pin_oe
);
    logic [2:0] run_cnt;
    logic       last_wr;
    logic       free_run;
    logic       ctc_hit;
    // The tick is internal, so only the settled undivided select is trusted.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt <= 3'h0;
            last_wr <= 1'b0;
        end else begin
            last_wr <= counter_wr;
            if (clock_select_field != `TMW_CS_DIV1) begin
                run_cnt <= 3'h0;
            end else if (run_cnt != 3'h4) begin
                run_cnt <= run_cnt + 3'h1;
            end
        end
    end
    assign free_run = (run_cnt == 3'h4) && !counter_wr;
    assign ctc_hit = free_run && !last_wr && !compare_wr
        && waveform_mode_field == `TMW_WGM_CTC
        && counter_value == compare_value_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ctc_clear_top: assert property (
        ctc_hit |=> counter_value == 8'h00 && compare_match_flag)
        else $error("compare match did not clear the counter");
    a_ctc_toggle_pin: assert property (
        ctc_hit && compare_output_mode_field == `TMW_COM_TOGGLE
        |=> pin_out != $past(pin_out))
        else $error("toggle mode did not invert the output");
    a_fast_wrap_max: assert property (
        free_run && waveform_mode_field == `TMW_WGM_FASTPWM
        && counter_value == 8'hFF |=> counter_value == 8'h00 && overflow_flag)
        else $error("fast mode did not wrap with overflow");
    a_fast_count_up: assert property (
        free_run && waveform_mode_field == `TMW_WGM_FASTPWM
        && counter_value != 8'hFF
        |=> counter_value == $past(counter_value) + 8'h01)
        else $error("fast mode did not count up");
    a_pc_top_turn: assert property (
        free_run && waveform_mode_field == `TMW_WGM_PCPWM
        && counter_value == 8'hFF |=> counter_value == 8'hFE)
        else $error("dual slope did not turn down at max");
    a_pc_bottom_flag: assert property (
        free_run && waveform_mode_field == `TMW_WGM_PCPWM
        && counter_value == 8'h00 |=> overflow_flag)
        else $error("overflow flag missing at bottom");
    a_write_blocks_match: assert property (
        run_cnt == 3'h4 && counter_wr && !compare_wr && !compare_match_flag
        && waveform_mode_field == `TMW_WGM_CTC
        && counter_value != compare_value_reg
        && counter_wdata == compare_value_reg |=> ##1 !compare_match_flag)
        else $error("match not blocked after counter write");
    a_flag_sticky: assert property (
        compare_match_flag && !compare_flag_clr |=> compare_match_flag)
        else $error("compare flag dropped without a clear");
    a_pin_dir_follow: assert property (
        $past(rst_n) && $past(rst_n, 2) |-> pin_oe == $past(port_dir_out))
        else $error("pin enable does not follow direction");
    c_ctc_hit: cover property (ctc_hit);
    c_fast_wrap: cover property (free_run && counter_value == 8'hFF
        && waveform_mode_field == `TMW_WGM_FASTPWM);
    c_pc_top: cover property (free_run && counter_value == 8'hFF
        && waveform_mode_field == `TMW_WGM_PCPWM);
endmodule

// ===== verification/tb_top.sv
/* Self-checking bench for the 8-bit timer waveform block.
   Assumes tmw_timer and the checker are compiled first. */
`timescale 1ns/1ps
`include "tmw_consts.vh"
////////////////////////////////////////////////////////////////////////////
module tb_top;
    logic       clk = 1'b0, rst_n = 1'b0, compare_wr = 1'b0, counter_wr = 1'b0;
    logic [1:0] mode = `TMW_WGM_CTC, com = `TMW_COM_TOGGLE;
    logic [2:0] cs = `TMW_CS_DIV1;
    logic       ext_in = 1'b0, cmp_clr = 1'b0, ovf_clr = 1'b0;
    logic       port_data = 1'b0, port_dir_out = 1'b1;
    logic [7:0] wdata = 8'h00, counter_value, compare_value_reg;
    logic       compare_match_flag, overflow_flag, pin_out, pin_oe;
    logic [15:0] hi;
    int         err_total = 0, comparisons = 0, cycles = 0;
    // Rows: mode, output mode, compare, window, expected high cycles.
    logic [35:0] rows [10] = '{
        {2'h3, 2'h2, 8'h40, 12'h100, 12'h041},
        {2'h3, 2'h3, 8'h40, 12'h100, 12'h0BF},
        {2'h3, 2'h2, 8'hFF, 12'h100, 12'h100},
        {2'h3, 2'h2, 8'h00, 12'h100, 12'h001},
        {2'h3, 2'h1, 8'h7F, 12'h200, 12'h100},
        {2'h1, 2'h2, 8'h40, 12'h1FE, 12'h080},
        {2'h1, 2'h3, 8'h40, 12'h1FE, 12'h17E},
        {2'h1, 2'h2, 8'h00, 12'h1FE, 12'h000},
        {2'h1, 2'h2, 8'hFF, 12'h1FE, 12'h1FE},
        {2'h1, 2'h2, 8'h40, 12'h1FE, 12'h080}};

    tmw_timer dut_u (
        .clk(clk), .rst_n(rst_n), .waveform_mode_field(mode),
        .compare_output_mode_field(com), .clock_select_field(cs),
        .external_count_input(ext_in), .compare_wr(compare_wr),
        .compare_wdata(wdata), .counter_wr(counter_wr),
        .counter_wdata(wdata), .compare_flag_clr(cmp_clr),
        .overflow_flag_clr(ovf_clr), .port_data(port_data),
        .port_dir_out(port_dir_out), .counter_value(counter_value),
        .compare_value_reg(compare_value_reg),
        .compare_match_flag(compare_match_flag),
        .overflow_flag(overflow_flag), .pin_out(pin_out), .pin_oe(pin_oe));

    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Both write strobes share one data bus; only one is raised at a time.
    task automatic wr(input logic to_counter, input logic [7:0] v);
        wdata = v;
        if (to_counter) counter_wr = 1'b1;
        else compare_wr = 1'b1;
        cyc(1);
        if (to_counter) counter_wr = 1'b0;
        else compare_wr = 1'b0;
    endtask
    task automatic wait_cnt(input logic [7:0] v);
        int n;
        n = 0;
        while (counter_value !== v && n < 600) begin
            cyc(1);
            n++;
        end
        check(16'(counter_value), 16'(v));
    endtask
    task automatic measure(input int len);
        hi = 16'h0000;
        repeat (len) begin
            cyc(1);
            if (pin_out === 1'b1) hi = hi + 16'h0001;
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        wr(1'b0, 8'h03);
        cmp_clr = 1'b1;
        cyc(1);
        cmp_clr = 1'b0;
        wait_cnt(8'h03);
        check(16'(compare_match_flag), 16'h0000);
        cyc(1);
        check(16'(counter_value), 16'h0000);
        check(16'(compare_match_flag), 16'h0001);
        measure(8);
        check(hi, 16'h0004);
        cs = `TMW_CS_DIV8;
        wr(1'b0, 8'h00);
        // Park the count at MAX so the new zero top is met after one wrap.
        wr(1'b1, 8'hFF);
        cyc(40);
        measure(32);
        check(hi, 16'h0010);
        cs = `TMW_CS_DIV1;
        // Let the undivided tick settle before the blocked-match step.
        cyc(4);
        $display("test ctc_basic done");
        wr(1'b0, 8'hF0);
        wr(1'b1, 8'h10);
        cmp_clr = 1'b1;
        ovf_clr = 1'b1;
        cyc(1);
        cmp_clr = 1'b0;
        ovf_clr = 1'b0;
        wr(1'b1, 8'hF0);
        cyc(1);
        check(16'(counter_value), 16'h00F1);
        check(16'(compare_match_flag), 16'h0000);
        wr(1'b0, 8'h05);
        wait_cnt(8'hFF);
        check(16'(compare_match_flag), 16'h0000);
        check(16'(overflow_flag), 16'h0000);
        cyc(1);
        check(16'(counter_value), 16'h0000);
        check(16'(overflow_flag), 16'h0001);
        wait_cnt(8'h05);
        cyc(1);
        check(16'(compare_match_flag), 16'h0001);
        $display("test ctc_wrap done");
        com = `TMW_COM_OFF;
        port_data = 1'b1;
        cyc(2);
        check(16'(pin_out), 16'h0001);
        check(16'(pin_oe), 16'h0001);
        port_dir_out = 1'b0;
        cyc(2);
        check(16'(pin_oe), 16'h0000);
        port_dir_out = 1'b1;
        $display("test pin_select done");
        for (int i = 0; i < 10; i++) begin
            mode = rows[i][35:34];
            com = rows[i][33:32];
            wr(1'b0, rows[i][31:24]);
            // The buffered value must wait for the wrap before it lands.
            if (i == 0) check(16'(compare_value_reg), 16'h0005);
            // Leaving MAX must drop the output at MAX without a match.
            if (i == 9) begin
                wait_cnt(8'hFF);
                check(16'(pin_out), 16'h0001);
                cyc(1);
                check(16'(pin_out), 16'h0000);
            end
            cyc(1200);
            check(16'(compare_value_reg), 16'(rows[i][31:24]));
            measure(int'(rows[i][23:12]));
            check(hi, 16'(rows[i][11:0]));
        end
        $display("test pwm_table done");
        close_out();
    end
endmodule

bind tmw_timer tmw_properties chk_u (
    .clk(clk), .rst_n(rst_n), .waveform_mode_field(waveform_mode_field),
    .compare_output_mode_field(compare_output_mode_field),
    .clock_select_field(clock_select_field), .compare_wr(compare_wr),
    .counter_wr(counter_wr), .counter_wdata(counter_wdata),
    .compare_flag_clr(compare_flag_clr), .port_dir_out(port_dir_out),
    .counter_value(counter_value), .compare_value_reg(compare_value_reg),
    .compare_match_flag(compare_match_flag), .overflow_flag(overflow_flag),
    .pin_out(pin_out), .pin_oe(pin_oe));
